//--- hdl/address_breakpoint_unit.sv
`include "address_breakpoint_unit_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module address_breakpoint_unit
  import address_breakpoint_unit_pkg::*;
(
  input wire logic clock,
  input wire logic rst,
  // processor side
  input wire logic [15:0] cpu_address,
  input wire logic cpu_opcode_fetch,
  input wire logic cpu_wait_mode,
  input wire logic cpu_stop_mode,
  input wire logic emulation_mode,
  output logic breakpoint_request,
  output logic break_state,
  output logic flag_clear_enable,
  output logic irq,
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  brk_state_t st;
  brk_state_t next_st;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic addr_match;
  logic halted;
  logic do_write;
  logic [7:0] wbyte;
  logic [31:0] rd_word;
  logic rd_ok;

  // handshake readiness is combinational, data are registered
  assign s_axi_awready = (st.wr_state == wr_idle) && !st.have_aw;
  assign s_axi_wready = (st.wr_state == wr_idle) && !st.have_w;
  assign s_axi_bvalid = (st.wr_state == wr_resp);
  assign s_axi_bresp = st.b_resp;
  assign s_axi_arready = !st.rd_valid;
  assign s_axi_rvalid = st.rd_valid;
  assign s_axi_rdata = st.r_data;
  assign s_axi_rresp = st.r_resp;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;

  // no advancing bus in low power
  assign halted = cpu_wait_mode || cpu_stop_mode;
  assign addr_match = st.breakpoint_enable && !halted &&
                      (cpu_address == {st.break_address_high, st.break_address_low});

  assign breakpoint_request = st.breakpoint_request;
  assign break_state = st.break_active;
  assign flag_clear_enable = st.flag_clear_enable;
  // level interrupt from unmasked sticky bits
  assign irq = |(st.irq_status & st.irq_mask);

  // read mux; only the low byte carries data
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `OFS_BREAK_CONTROL_STATUS: begin
        rd_word[`BIT_BREAKPOINT_ENABLE] = st.breakpoint_enable;
        rd_word[`BIT_BREAK_ACTIVE] = st.break_active;
      end
      `OFS_BREAK_ADDRESS_HIGH: rd_word[7:0] = st.break_address_high;
      `OFS_BREAK_ADDRESS_LOW: rd_word[7:0] = st.break_address_low;
      // wait-exit flag readable in break routine
      `OFS_BREAK_WAIT_EXIT_STATUS: rd_word[`BIT_WAIT_EXITED_BY_BREAK] = st.wait_exited_by_break;
      `OFS_BREAK_FLAG_CLEAR_CONTROL: rd_word[`BIT_FLAG_CLEAR_ENABLE] = st.flag_clear_enable;
      `OFS_IRQ_STATUS: rd_word[1:0] = st.irq_status;
      `OFS_IRQ_MASK: rd_word[1:0] = st.irq_mask;
      default: rd_ok = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  always_comb begin
    next_st = st;
    do_write = 1'b0;
    wbyte = st.w_data[7:0];
    next_st.breakpoint_request = 1'b0;

    // write channels, accepted in either order
    if (aw_take) begin
      next_st.have_aw = 1'b1;
      next_st.aw_addr = s_axi_awaddr;
    end
    if (w_take) begin
      next_st.have_w = 1'b1;
      next_st.w_data = s_axi_wdata;
      next_st.w_strb = s_axi_wstrb;
    end

    case (st.wr_state)
      wr_idle: begin
        if (st.have_aw && st.have_w) begin
          // only byte lane 0 holds register bits
          do_write = st.w_strb[0];
          next_st.have_aw = 1'b0;
          next_st.have_w = 1'b0;
          next_st.wr_state = wr_resp;
          next_st.b_resp = `RESP_OKAY;
          case (st.aw_addr)
            `OFS_BREAK_CONTROL_STATUS, `OFS_BREAK_ADDRESS_HIGH, `OFS_BREAK_ADDRESS_LOW,
            `OFS_BREAK_WAIT_EXIT_STATUS, `OFS_BREAK_FLAG_CLEAR_CONTROL,
            `OFS_IRQ_STATUS, `OFS_IRQ_MASK: next_st.b_resp = `RESP_OKAY;
            default: begin
              next_st.b_resp = `RESP_SLVERR;
              do_write = 1'b0;
            end
          endcase
        end
      end
      wr_resp: begin
        if (s_axi_bready) begin
          next_st.wr_state = wr_idle;
        end
      end
      default: next_st.wr_state = wr_idle;
    endcase

    // register writes
    if (do_write) begin
      case (st.aw_addr)
        `OFS_BREAK_CONTROL_STATUS: begin
          next_st.breakpoint_enable = wbyte[`BIT_BREAKPOINT_ENABLE];
          next_st.break_active = wbyte[`BIT_BREAK_ACTIVE];
          if (wbyte[`BIT_BREAK_ACTIVE]) begin
            // issued at once, ahead of next instruction
            next_st.breakpoint_request = 1'b1;
            next_st.irq_status[`BIT_IRQ_SOFT] = 1'b1;
          end
        end
        `OFS_BREAK_ADDRESS_HIGH: next_st.break_address_high = wbyte;
        `OFS_BREAK_ADDRESS_LOW: next_st.break_address_low = wbyte;
        `OFS_BREAK_WAIT_EXIT_STATUS: begin
          // clearing only allowed with flag-clear enable
          if (st.flag_clear_enable && !wbyte[`BIT_WAIT_EXITED_BY_BREAK]) begin
            next_st.wait_exited_by_break = 1'b0;
          end
        end
        `OFS_BREAK_FLAG_CLEAR_CONTROL: next_st.flag_clear_enable = wbyte[`BIT_FLAG_CLEAR_ENABLE];
        `OFS_IRQ_STATUS: next_st.irq_status = st.irq_status & ~wbyte[1:0];
        `OFS_IRQ_MASK: next_st.irq_mask = wbyte[1:0];
        default: next_st.irq_mask = st.irq_mask;
      endcase
    end

    // one pulse per match event, edge of the compare
    next_st.match_seen = addr_match;
    if (addr_match && !st.match_seen) begin
      // hardware sets break-active, wins over a clear
      next_st.break_active = 1'b1;
      // request follows any matching address; cpu_opcode_fetch is not decoded
      next_st.breakpoint_request = 1'b1;
      next_st.irq_status[`BIT_IRQ_MATCH] = 1'b1;
    end

    // wait-exit tracking only in emulation mode
    // set when a break ends wait mode
    next_st.in_wait = cpu_wait_mode;
    if (emulation_mode && st.in_wait && !cpu_wait_mode && st.break_active) begin
      next_st.wait_exited_by_break = 1'b1;
    end

    // read channel
    if (ar_take) begin
      next_st.rd_valid = 1'b1;
      next_st.r_data = rd_word;
      next_st.r_resp = rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (st.rd_valid && s_axi_rready) begin
      next_st.rd_valid = 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      next_st_reset();
    end else begin
      st <= next_st;
    end
  end

  // reset image held in one place so every field gets a constant
  task automatic next_st_reset();
    st.wr_state <= wr_idle;
    st.have_aw <= 1'b0;
    st.have_w <= 1'b0;
    st.aw_addr <= `RST_BYTE;
    st.w_data <= 32'h0000_0000;
    st.w_strb <= 4'h0;
    st.b_resp <= `RESP_OKAY;
    st.rd_valid <= 1'b0;
    st.r_data <= 32'h0000_0000;
    st.r_resp <= `RESP_OKAY;
    st.breakpoint_enable <= 1'b0;
    st.break_active <= 1'b0;
    st.break_address_high <= `RST_BYTE;
    st.break_address_low <= `RST_BYTE;
    st.wait_exited_by_break <= 1'b0;
    st.flag_clear_enable <= 1'b0;
    st.breakpoint_request <= 1'b0;
    st.match_seen <= 1'b0;
    st.in_wait <= 1'b0;
    st.irq_status <= 2'b00;
    st.irq_mask <= 2'b00;
  endtask

endmodule

`default_nettype wire

//--- hdl/address_breakpoint_unit_defines.svh
`ifndef ADDRESS_BREAKPOINT_UNIT_DEFINES_SVH
`define ADDRESS_BREAKPOINT_UNIT_DEFINES_SVH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFS_BREAK_CONTROL_STATUS 8'h00
`define OFS_BREAK_ADDRESS_HIGH 8'h04
`define OFS_BREAK_ADDRESS_LOW 8'h08
`define OFS_BREAK_WAIT_EXIT_STATUS 8'h0C
`define OFS_BREAK_FLAG_CLEAR_CONTROL 8'h10
`define OFS_IRQ_STATUS 8'h14
`define OFS_IRQ_MASK 8'h18

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_BREAKPOINT_ENABLE 7
`define BIT_BREAK_ACTIVE 6
`define BIT_WAIT_EXITED_BY_BREAK 1
`define BIT_FLAG_CLEAR_ENABLE 0
`define BIT_IRQ_MATCH 0
`define BIT_IRQ_SOFT 1

// ----------------------------------------------------------------
// reset values and bus answers
// ----------------------------------------------------------------
`define RST_BYTE 8'h00
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

//--- hdl/address_breakpoint_unit_pkg.sv
package address_breakpoint_unit_pkg;

  typedef enum logic [1:0] {
    wr_idle = 2'b00,
    wr_resp = 2'b01
  } wr_state_t;

  typedef struct packed {
    wr_state_t wr_state;
    logic have_aw;
    logic have_w;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic [1:0] b_resp;
    logic rd_valid;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    logic breakpoint_enable;
    logic break_active;
    logic [7:0] break_address_high;
    logic [7:0] break_address_low;
    logic wait_exited_by_break;
    logic flag_clear_enable;
    logic breakpoint_request;
    logic match_seen;
    logic in_wait;
    logic [1:0] irq_status;
    logic [1:0] irq_mask;
  } brk_state_t;

endpackage

//--- tb/abu_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module abu_monitor (
  input wire logic clock,
  input wire logic rst,
  input wire logic cpu_wait_mode,
  input wire logic cpu_stop_mode,
  input wire logic breakpoint_request,
  input wire logic break_state,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // read request taken
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_req_marks_state: assert property (breakpoint_request |-> break_state)
    else $error("request without break state");
  a_req_one_pulse: assert property (breakpoint_request |=> !breakpoint_request)
    else $error("request held too long");
  a_low_power_quiet: assert property ((cpu_wait_mode || cpu_stop_mode) |=> !breakpoint_request)
    else $error("request in low power");
  a_state_has_req: assert property ($rose(break_state) |-> ##[0:2] breakpoint_request)
    else $error("break state without request");
  a_rd_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("late read answer");
  a_rd_done: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
endmodule
bind address_breakpoint_unit abu_monitor i_abu_monitor (.clock, .rst, .cpu_wait_mode,
  .cpu_stop_mode, .breakpoint_request, .break_state, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata);
`default_nettype wire

//--- tb/cpu_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_bus_model (
  input wire logic clock,
  output logic [15:0] cpu_address,
  output logic cpu_opcode_fetch,
  output logic cpu_wait_mode,
  output logic cpu_stop_mode,
  output logic emulation_mode
);
  // core idle at reset
  initial cpu_address = 16'h0000;
  initial cpu_opcode_fetch = 1'h0;
  initial cpu_wait_mode = 1'h0;
  initial cpu_stop_mode = 1'h0;
  initial emulation_mode = 1'h0;
  // bus frozen in low power
  // one address held n cycles, as the core does while waiting
  task automatic step(input logic [15:0] a, input logic w, input logic s, input int n);
    @(posedge clock);
    cpu_address <= a;
    cpu_opcode_fetch <= 1'h1;
    cpu_wait_mode <= w;
    cpu_stop_mode <= s;
    repeat (n - 1) @(posedge clock);
  endtask
  task automatic emu(input logic e);
    @(posedge clock);
    emulation_mode <= e;
  endtask
endmodule
`default_nettype wire

//--- tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'h0;
  logic rst = 1'h1;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, breakpoint_request, break_state;
  logic flag_clear_enable, irq, cpu_opcode_fetch, cpu_wait_mode, cpu_stop_mode, emulation_mode;
  logic [1:0] bresp, rresp, r;
  logic [15:0] cpu_address;
  int bad_count = 0, checked = 0, pulses = 0;
  address_breakpoint_unit i_address_breakpoint_unit (.clock, .rst, .cpu_address,
    .cpu_opcode_fetch, .cpu_wait_mode, .cpu_stop_mode, .emulation_mode, .breakpoint_request,
    .break_state, .flag_clear_enable, .irq, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  cpu_bus_model i_cpu_bus_model (.clock, .cpu_address, .cpu_opcode_fetch, .cpu_wait_mode,
    .cpu_stop_mode, .emulation_mode);
  // 25 ns bus clock
  initial forever #12.5 clock = ~clock;
  // count break requests seen by the core
  always @(posedge clock) if (breakpoint_request === 1'h1) pulses++;
  task close_out;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task hang;
    bad_count++;
    close_out;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t saw %h expected %h", $time, seen, exp);
    end
  endtask
  // halves released as taken; slave may take them in either order
  task wr(input logic [7:0] a, input logic [31:0] v);
    int n;
    @(posedge clock);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    r = bresp;
    bready <= 1'h0;
    if (n == 40) hang();
  endtask
  task rd(input logic [7:0] a);
    int n;
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (n = 0; n < 40; n++) begin
      @(posedge clock);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    if (n == 40) hang();
  endtask
  task go(input logic [15:0] a, input logic w, input logic s, input int n);
    i_cpu_bus_model.step(a, w, s, n);
  endtask
  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'h0;
    // registers 0x00 to 0x10 clear after reset
    for (int i = 0; i < 5; i++) begin
      rd(8'(i * 4));
      chk(d, 32'h0);
    end
    wr(8'h04, 32'h12);
    wr(8'h08, 32'h34);
    rd(8'h04);
    chk(d, 32'h12);
    rd(8'h08);
    chk(d, 32'h34);
    // lane 0 strobe off: write answered but register kept
    wstrb <= 4'h0;
    wr(8'h04, 32'h99);
    chk(32'(r), 32'(`RESP_OKAY));
    wstrb <= 4'hF;
    rd(8'h04);
    chk(d, 32'h12);
    // match while disabled must stay silent
    go(16'h1234, 1'h0, 1'h0, 3);
    go(16'h0000, 1'h0, 1'h0, 3);
    chk(pulses, 0);
    wr(8'h00, 32'h80);
    rd(8'h00);
    chk(d, 32'h80);
    // near miss, then a held match gives one request
    go(16'h1235, 1'h0, 1'h0, 2);
    go(16'h1234, 1'h0, 1'h0, 4);
    go(16'h0000, 1'h0, 1'h0, 3);
    chk(pulses, 1);
    rd(8'h00);
    chk(d, 32'hC0);
    chk(break_state, 1'h1);
    rd(8'h14);
    chk(d, 32'h1);
    chk(irq, 1'h0);
    wr(8'h18, 32'h3);
    chk(irq, 1'h1);
    wr(8'h14, 32'h1);
    chk(irq, 1'h0);
    wr(8'h00, 32'h80);
    rd(8'h00);
    chk(d, 32'h80);
    // frozen bus in wait and stop
    go(16'h1234, 1'h1, 1'h0, 3);
    go(16'h1234, 1'h0, 1'h1, 3);
    go(16'h0000, 1'h0, 1'h0, 3);
    chk(pulses, 1);
    rd(8'h00);
    chk(d, 32'h80);
    wr(8'h00, 32'hC0);
    go(16'h0000, 1'h0, 1'h0, 3);
    chk(pulses, 2);
    rd(8'h14);
    chk(d, 32'h2);
    // wait exit outside emulation is not tracked
    go(16'h0000, 1'h1, 1'h0, 3);
    go(16'h0000, 1'h0, 1'h0, 2);
    rd(8'h0C);
    chk(d, 32'h0);
    i_cpu_bus_model.emu(1'h1);
    go(16'h0000, 1'h1, 1'h0, 3);
    go(16'h0000, 1'h0, 1'h0, 2);
    rd(8'h0C);
    // routine may rewind its return address once this flag is seen
    chk(d, 32'h2);
    wr(8'h0C, 32'h0);
    rd(8'h0C);
    chk(d, 32'h2);
    wr(8'h10, 32'h1);
    chk(flag_clear_enable, 1'h1);
    wr(8'h0C, 32'h0);
    rd(8'h0C);
    chk(d, 32'h0);
    // unmapped place answers with an error
    wr(8'h1C, 32'h5);
    chk(32'(r), 32'(`RESP_SLVERR));
    rd(8'h1C);
    chk(32'(r), 32'(`RESP_SLVERR));
    close_out;
  end
endmodule
`default_nettype wire
